// >>> include/hpm_defs.svh
// Offsets, field positions, reset values and strap codes of the pin mux
`ifndef HPM_DEFS_SVH
`define HPM_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HPM_ADDR_W 8
`define HPM_OFS_DISP_MODE 8'h02
`define HPM_OFS_PANEL_CFG 8'h20
`define HPM_OFS_STATUS 8'h21

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define HPM_VINV_EN_BIT 1
`define HPM_FMT_LSB 0
`define HPM_FMT_MSB 3
`define HPM_PWR_ON_BIT 4
`define HPM_DISP_MODE_RST 8'h00
`define HPM_PANEL_CFG_RST 8'h00

// ----------------------------------------------------------------------
// Host select strap codes
// ----------------------------------------------------------------------
`define HPM_SEL_SYNC_A 3'h0
`define HPM_SEL_SYNC_B 3'h1
`define HPM_SEL_ASTB_1 3'h3
`define HPM_SEL_ASTB_2 3'h5
`define HPM_SEL_GENERIC 3'h7

`endif

// >>> include/hpm_pkg.sv
// Types shared by the pin mux modules
`default_nettype none
package hpm_pkg;
	typedef enum logic [2:0] {
		HPM_HOST_SYNC_A = 3'b000,
		HPM_HOST_SYNC_B = 3'b001,
		HPM_HOST_ASTB_1 = 3'b010,
		HPM_HOST_ASTB_2 = 3'b011,
		HPM_HOST_GEN_1 = 3'b100,
		HPM_HOST_GEN_2 = 3'b101,
		HPM_HOST_RESERVED = 3'b111
	} hpm_host_t;

	typedef enum logic [3:0] {
		HPM_FMT_MONO4 = 4'b0000,
		HPM_FMT_MONO8 = 4'b0001,
		HPM_FMT_MONO8_DUAL = 4'b0010,
		HPM_FMT_COL4 = 4'b0011,
		HPM_FMT_COL8_F1 = 4'b0100,
		HPM_FMT_COL8_F2 = 4'b0101,
		HPM_FMT_COL8_DUAL = 4'b0110,
		HPM_FMT_TFT9 = 4'b0111,
		HPM_FMT_TFT12 = 4'b1000
	} hpm_fmt_t;
endpackage : hpm_pkg
`default_nettype wire

// >>> include/hpm_strap_if.sv
// Latched strap values passed from the strap latch to the pin mux
`default_nettype none
interface hpm_strap_if;
	logic power_active_high;
	logic big_endian;
	hpm_pkg::hpm_host_t host_mode;

	modport latch (output power_active_high, output big_endian,
		output host_mode);
	modport user (input power_active_high, input big_endian,
		input host_mode);
endinterface : hpm_strap_if
`default_nettype wire

// >>> src/hpm_strap_latch.sv
// Strap capture and host style decode
`include "hpm_defs.svh"
`default_nettype none
module hpm_strap_latch
	import hpm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Strap pins
	input wire logic panel_power_polarity_strap,
	input wire logic byte_order_strap,
	input wire logic [2:0] host_select_strap,
	input wire logic bus_start_n,
	// Latched values
	hpm_strap_if.latch straps
);
	hpm_host_t next_host_mode;

	// ------------------------------------------------------------------
	// Host style decode
	// ------------------------------------------------------------------
	always_comb begin
		case (host_select_strap) // R3
			`HPM_SEL_SYNC_A: next_host_mode = HPM_HOST_SYNC_A;
			`HPM_SEL_SYNC_B: next_host_mode = HPM_HOST_SYNC_B;
			`HPM_SEL_ASTB_1: next_host_mode = HPM_HOST_ASTB_1;
			`HPM_SEL_ASTB_2: next_host_mode = HPM_HOST_ASTB_2;
			`HPM_SEL_GENERIC: next_host_mode = bus_start_n ?
				HPM_HOST_GEN_2 : HPM_HOST_GEN_1; // R4
			default: next_host_mode = HPM_HOST_RESERVED;
		endcase
	end

	// ------------------------------------------------------------------
	// Capture while reset is held, frozen after release
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin // R12
			straps.power_active_high <= panel_power_polarity_strap; // R1
			straps.big_endian <= byte_order_strap; // R2
			straps.host_mode <= next_host_mode;
		end
	end

	strap_hold_a: assert property (@(posedge ref_clk) // R12
		rst_b && $past(rst_b) |-> $stable(straps.host_mode) &&
		$stable(straps.big_endian) && $stable(straps.power_active_high))
		else $error("strap value changed outside reset");

	strap_decode_a: assert property (@(posedge ref_clk) // R3
		!rst_b && host_select_strap == 3'h7 && !bus_start_n |=>
		straps.host_mode == HPM_HOST_GEN_1)
		else $error("generic host 1 not selected");
endmodule : hpm_strap_latch
`default_nettype wire

// >>> src/hpm_pin_mux.sv
// Host and panel pin multiplexer top level
//
// How it works
// R1 - Panel power is active high when polarity strap is 1, else low.
// R2 - Byte order strap 1 swaps host bytes big-endian; 0 is little-endian.
// R3 - Host select strap picks one of six 16-bit host styles.
// R4 - Board ties bus start low or high to choose generic host.
// R5 - Address-strobe host 1 strobes on address bit 0 and upper write.
// R6 - Address-strobe host 2 takes size bits on read and lower write.
// R7 - 4-bit passive data on pins 7 to 4; dual splits nibbles.
// R8 - Aux pin carries bias, second shift clock, or display enable.
// R9 - 9-bit TFT uses pins 0 to 8; 12-bit uses all twelve.
// R10 - Video invert enable turns free pin 11 into an invert input.
// R11 - Reset clears registers, drives the strobe, panel and power outputs inactive and host wait high, which is a wait in both address-strobe styles.
// R12 - Straps are captured during reset and held until the next.
`include "hpm_defs.svh"
`default_nettype none
module hpm_pin_mux
	import hpm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Straps
	input wire logic panel_power_polarity_strap,
	input wire logic byte_order_strap,
	input wire logic [2:0] host_select_strap,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Host pins
	input wire logic bus_start_n,
	input wire logic address_bit_zero,
	input wire logic upper_write_strobe_n,
	input wire logic lower_write_strobe_n,
	input wire logic read_n,
	input wire logic [15:0] host_data_bus_in,
	output logic [15:0] host_data_bus_out,
	output logic host_wait_n,
	// Host side toward the core
	input wire logic [15:0] core_rdata,
	input wire logic core_busy,
	output logic [15:0] core_wdata,
	output logic core_lo_strobe_n,
	output logic core_hi_strobe_n,
	output logic [1:0] core_size,
	output logic core_addr0,
	output logic core_upper_half,
	// Panel timing sources
	input wire logic [11:0] pixel_in,
	input wire logic frame_in,
	input wire logic line_in,
	input wire logic shift_in,
	input wire logic shift2_in,
	input wire logic bias_in,
	input wire logic display_enable_in,
	input wire logic [3:0] gpio_out,
	input wire logic [3:0] gpio_oe,
	// Panel pins
	output logic [11:0] panel_data_pins_out,
	output logic [11:0] panel_data_pins_oe,
	input wire logic [11:8] panel_data_pins_in,
	output logic frame_pulse,
	output logic line_pulse,
	output logic panel_shift_clock,
	output logic panel_aux_out,
	output logic panel_power_out,
	output logic video_invert
);
	hpm_strap_if straps ();
	logic [7:0] disp_mode;
	logic [7:0] panel_cfg;
	hpm_fmt_t fmt;
	logic tft;
	logic [11:0] next_data;
	logic [11:8] next_oe;
	logic pin11_free;

	// ------------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------------
	hpm_strap_latch u_straps (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.panel_power_polarity_strap(panel_power_polarity_strap),
		.byte_order_strap(byte_order_strap),
		.host_select_strap(host_select_strap),
		.bus_start_n(bus_start_n),
		.straps(straps.latch)
	);

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin // R11
			disp_mode <= `HPM_DISP_MODE_RST;
			panel_cfg <= `HPM_PANEL_CFG_RST;
		end else if (reg_wr) begin
			if (reg_addr == `HPM_OFS_DISP_MODE)
				disp_mode <= reg_wdata;
			if (reg_addr == `HPM_OFS_PANEL_CFG)
				panel_cfg <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`HPM_OFS_DISP_MODE: reg_rdata <= disp_mode;
				`HPM_OFS_PANEL_CFG: reg_rdata <= panel_cfg;
				`HPM_OFS_STATUS: reg_rdata <= {2'h0, video_invert,
					straps.host_mode, straps.big_endian,
					straps.power_active_high};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Host pin mapping
	// ------------------------------------------------------------------
	always_comb begin
		core_wdata = straps.big_endian ? // R2
			{host_data_bus_in[7:0], host_data_bus_in[15:8]} :
			host_data_bus_in;
		host_data_bus_out = straps.big_endian ?
			{core_rdata[7:0], core_rdata[15:8]} : core_rdata;
		core_addr0 = address_bit_zero;
		core_lo_strobe_n = lower_write_strobe_n;
		core_hi_strobe_n = upper_write_strobe_n;
		core_size = 2'h0;
		core_upper_half = 1'b0;
		host_wait_n = !core_busy;
		case (straps.host_mode)
			HPM_HOST_ASTB_1: begin // R5
				core_addr0 = 1'b0;
				core_lo_strobe_n = address_bit_zero;
				core_hi_strobe_n = upper_write_strobe_n;
				host_wait_n = core_busy;
			end
			HPM_HOST_ASTB_2: begin // R6
				core_size = {read_n, lower_write_strobe_n};
				core_upper_half = 1'b1;
				core_lo_strobe_n = upper_write_strobe_n;
				host_wait_n = core_busy;
			end
			HPM_HOST_GEN_2: core_hi_strobe_n = upper_write_strobe_n; // R4
			HPM_HOST_RESERVED: host_wait_n = 1'b1;
			default: host_wait_n = !core_busy;
		endcase
		if (!rst_b) begin // R11
			host_wait_n = 1'b1;
			core_lo_strobe_n = 1'b1;
			core_hi_strobe_n = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Panel data mapping
	// ------------------------------------------------------------------
	assign fmt = hpm_fmt_t'(panel_cfg[`HPM_FMT_MSB:`HPM_FMT_LSB]);
	assign tft = fmt == HPM_FMT_TFT9 || fmt == HPM_FMT_TFT12;
	assign pin11_free = fmt != HPM_FMT_TFT12;

	always_comb begin
		next_data = {gpio_out, 8'h00};
		next_oe = gpio_oe;
		case (fmt)
			HPM_FMT_MONO4, HPM_FMT_COL4: // R7
				next_data[7:0] = {pixel_in[3:0], 4'h0};
			HPM_FMT_TFT9: begin // R9
				next_data[8:0] = {pixel_in[0], pixel_in[1], pixel_in[2],
					pixel_in[3], pixel_in[4], pixel_in[5],
					pixel_in[6], pixel_in[7], pixel_in[8]};
				next_oe[8] = 1'b1;
			end
			HPM_FMT_TFT12: begin // R9
				next_data = {pixel_in[0], pixel_in[4], pixel_in[8],
					pixel_in[1], pixel_in[2], pixel_in[3],
					pixel_in[5], pixel_in[6], pixel_in[7],
					pixel_in[9], pixel_in[10], pixel_in[11]};
				next_oe = 4'hf;
			end
			default: next_data[7:0] = pixel_in[7:0]; // R7
		endcase
		if (pin11_free && disp_mode[`HPM_VINV_EN_BIT]) // R10
			next_oe[11] = 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin // R11
			panel_data_pins_out <= 12'h000;
			panel_data_pins_oe <= 12'h000;
		end else begin
			panel_data_pins_out <= next_data;
			panel_data_pins_oe <= {next_oe, 8'hff};
		end
	end

	// ------------------------------------------------------------------
	// Timing, aux, power and invert outputs
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin // R11
			frame_pulse <= 1'b0;
			line_pulse <= 1'b0;
			panel_shift_clock <= 1'b0;
			panel_aux_out <= 1'b0;
			video_invert <= 1'b0;
		end else begin
			frame_pulse <= frame_in;
			line_pulse <= line_in;
			panel_shift_clock <= shift_in;
			if (tft) // R8
				panel_aux_out <= display_enable_in;
			else if (fmt == HPM_FMT_COL8_F1)
				panel_aux_out <= shift2_in;
			else
				panel_aux_out <= bias_in;
			video_invert <= pin11_free && disp_mode[`HPM_VINV_EN_BIT] &&
				panel_data_pins_in[11]; // R10
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) // R11
			panel_power_out <= !straps.power_active_high;
		else // R1
			panel_power_out <= panel_cfg[`HPM_PWR_ON_BIT] ~^
				straps.power_active_high;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	power_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) |-> panel_power_out ==
		($past(panel_cfg[`HPM_PWR_ON_BIT]) == straps.power_active_high))
		else $error("panel power level wrong"); // R1
	swap_bytes_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		straps.big_endian |-> core_wdata[7:0] == host_data_bus_in[15:8])
		else $error("byte order not swapped"); // R2
	astb1_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		straps.host_mode == HPM_HOST_ASTB_1 |->
		core_lo_strobe_n == address_bit_zero && host_wait_n == core_busy)
		else $error("address strobe host 1 mapping wrong"); // R5
	astb2_size_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		straps.host_mode == HPM_HOST_ASTB_2 |->
		core_size == {read_n, lower_write_strobe_n} && core_upper_half)
		else $error("address strobe host 2 mapping wrong"); // R6
	nibble_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rst_b && fmt == HPM_FMT_MONO4 ##1 fmt == HPM_FMT_MONO4 |->
		panel_data_pins_out[3:0] == 4'h0 &&
		panel_data_pins_out[7:4] == $past(pixel_in[3:0]))
		else $error("4-bit panel data misplaced"); // R7
	aux_source_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rst_b && tft ##1 tft |-> panel_aux_out == $past(display_enable_in))
		else $error("aux pin not display enable"); // R8
	tft9_gpio_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rst_b && fmt == HPM_FMT_TFT9 ##1 fmt == HPM_FMT_TFT9 |->
		panel_data_pins_oe[8] && panel_data_pins_out[0] == $past(pixel_in[8]))
		else $error("9-bit panel mapping wrong"); // R9
	invert_input_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) && $past(pin11_free && disp_mode[`HPM_VINV_EN_BIT]) |->
		!panel_data_pins_oe[11])
		else $error("pin 11 driven while invert input"); // R10
	reset_quiet_a: assert property (@(posedge ref_clk)
		!$past(rst_b) |-> panel_data_pins_out == 12'h000 && !frame_pulse &&
		!panel_aux_out && panel_data_pins_oe[11:8] == 4'h0)
		else $error("outputs active after reset"); // R11
endmodule : hpm_pin_mux
`default_nettype wire

// >>> tb/hpm_host_model.sv
// Host board model driving the shared host pins
`default_nettype none
module hpm_host_model (
	// Clock and board choice
	input wire logic ref_clk,
	input wire logic [2:0] strap_sel,
	input wire logic gen2,
	// Host pins
	output logic bus_start_n,
	output logic address_bit_zero,
	output logic upper_write_strobe_n,
	output logic lower_write_strobe_n,
	output logic read_n,
	output logic [15:0] host_data_bus_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{bus_start_n, address_bit_zero, upper_write_strobe_n} = 3'h7;
		{lower_write_strobe_n, read_n} = 2'h3;
		host_data_bus_in = 16'h0000;
	end

	// Free pins take random values every cycle; tied pins follow the board choice
	always @(posedge ref_clk) begin
		{bus_start_n, address_bit_zero, upper_write_strobe_n} <= 3'($urandom);
		{read_n, lower_write_strobe_n} <= 2'($urandom);
		host_data_bus_in <= 16'($urandom);
		if (strap_sel == 3'h7)
			bus_start_n <= gen2;
		if (strap_sel == 3'h3)
			{read_n, lower_write_strobe_n} <= 2'h3;
	end
endmodule : hpm_host_model
`default_nettype wire

// >>> tb/host_and_panel_pin_mux_test.sv
// Self-checking bench for the host and panel pin mux
`default_nettype none
`include "hpm_defs.svh"
module host_and_panel_pin_mux_test;
	timeunit 1ns;
	timeprecision 1ns;

	// --------------------
	// Signals
	// --------------------
	logic ref_clk = 1'b0, rst_b = 1'b0, gen2 = 1'b0, pol, be;
	logic panel_power_polarity_strap = 1'b0, byte_order_strap = 1'b0;
	logic [2:0] host_select_strap = 3'h0, cur_sel = 3'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, core_busy = 1'b0;
	logic [15:0] core_rdata = 16'h0000, host_data_bus_in;
	logic [15:0] host_data_bus_out, core_wdata;
	logic [11:0] pixel_in = 12'h000, panel_data_pins_out, panel_data_pins_oe;
	logic frame_in = 0, line_in = 0, shift_in = 0, shift2_in = 0;
	logic bias_in = 0, display_enable_in = 0;
	logic [3:0] gpio_out = 4'h0, gpio_oe = 4'h0;
	logic [11:8] panel_data_pins_in = 4'h0;
	logic [1:0] core_size;
	logic bus_start_n, address_bit_zero, upper_write_strobe_n, read_n;
	logic lower_write_strobe_n, host_wait_n, core_lo_strobe_n;
	logic core_hi_strobe_n, core_addr0, core_upper_half, frame_pulse;
	logic line_pulse, panel_shift_clock, panel_aux_out, panel_power_out;
	logic video_invert;
	int error_cnt = 0, samples_checked = 0, mode;

	hpm_pin_mux i_dut (.ref_clk, .rst_b, .panel_power_polarity_strap,
		.byte_order_strap, .host_select_strap, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .bus_start_n, .address_bit_zero,
		.upper_write_strobe_n, .lower_write_strobe_n, .read_n,
		.host_data_bus_in, .host_data_bus_out, .host_wait_n, .core_rdata,
		.core_busy, .core_wdata, .core_lo_strobe_n, .core_hi_strobe_n,
		.core_size, .core_addr0, .core_upper_half, .pixel_in, .frame_in,
		.line_in, .shift_in, .shift2_in, .bias_in, .display_enable_in,
		.gpio_out, .gpio_oe, .panel_data_pins_out, .panel_data_pins_oe,
		.panel_data_pins_in, .frame_pulse, .line_pulse, .panel_shift_clock,
		.panel_aux_out, .panel_power_out, .video_invert);

	hpm_host_model i_host (.ref_clk, .strap_sel(cur_sel), .gen2,
		.bus_start_n, .address_bit_zero, .upper_write_strobe_n,
		.lower_write_strobe_n, .read_n, .host_data_bus_in);

	always #25 ref_clk = ~ref_clk;

	// --------------------
	// Tasks
	// --------------------
	task automatic chk(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd

	task automatic do_reset(input int c);
		logic [7:0] d;
		{pol, be} = 2'($urandom);
		mode = c[2:0] == 0 ? 0 : c[2:0] == 1 ? 1 : c[2:0] == 3 ? 2 :
			c[2:0] == 5 ? 3 : c[2:0] == 7 ? 4 + c[3] : 7;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		panel_power_polarity_strap <= pol;
		byte_order_strap <= be;
		host_select_strap <= 3'(c);
		cur_sel <= 3'(c);
		gen2 <= c[3];
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("oe in reset", panel_data_pins_oe, 0);
		chk("power in reset", panel_power_out, !pol);
		chk("wait in reset", host_wait_n, 1);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		{panel_power_polarity_strap, byte_order_strap, host_select_strap}
			<= 5'($urandom);
		rd(`HPM_OFS_STATUS, d);
		chk("status", d[4:0], {3'(mode), be, pol});
		wr(`HPM_OFS_STATUS, 8'hff);
		rd(`HPM_OFS_STATUS, d);
		chk("status kept", d[4:0], {3'(mode), be, pol});
		wr(8'h40, 8'hff);
		rd(8'h40, d);
		chk("unmapped", d, 0);
	endtask : do_reset

	task automatic host_chk;
		repeat (8) begin
			@(posedge ref_clk);
			core_rdata <= 16'($urandom);
			core_busy <= 1'($urandom);
			@(negedge ref_clk);
			chk("wdata", core_wdata, be ? {host_data_bus_in[7:0],
				host_data_bus_in[15:8]} : host_data_bus_in);
			chk("rdata", host_data_bus_out, be ? {core_rdata[7:0],
				core_rdata[15:8]} : core_rdata);
			if (mode == 2)
				chk("strobes", {core_addr0, core_lo_strobe_n, core_hi_strobe_n},
					{1'b0, address_bit_zero, upper_write_strobe_n});
			else
				chk("strobes", {core_addr0, core_lo_strobe_n, core_hi_strobe_n},
					{address_bit_zero, mode == 3 ? upper_write_strobe_n :
					lower_write_strobe_n, upper_write_strobe_n});
			chk("wait", host_wait_n, mode == 7 ? 1'b1 : mode == 2 ||
				mode == 3 ? core_busy : !core_busy);
			if (mode == 3)
				chk("size", {core_upper_half, core_size},
					{1'b1, read_n, lower_write_strobe_n});
			if (mode == 7)
				chk("reserved wait", host_wait_n, 1);
		end
	endtask : host_chk

	task automatic panel(input int f, input logic inv);
		logic [11:0] px, eo, ee;
		logic [5:0] t;
		logic [3:0] go, ge, gi;
		logic pw;
		int m12[12] = '{11, 10, 9, 7, 6, 5, 3, 2, 1, 8, 4, 0};
		pw = 1'($urandom);
		wr(`HPM_OFS_PANEL_CFG, {3'h0, pw, 4'(f)});
		wr(`HPM_OFS_DISP_MODE, {6'h00, inv, 1'b0});
		px = 12'($urandom);
		t = 6'($urandom);
		{go, ge, gi} = 12'($urandom);
		@(posedge ref_clk);
		pixel_in <= px;
		{frame_in, line_in, shift_in, shift2_in, bias_in,
			display_enable_in} <= t;
		{gpio_out, gpio_oe, panel_data_pins_in} <= {go, ge, gi};
		@(posedge ref_clk);
		@(negedge ref_clk);
		ee = {ge, 8'hff};
		eo = {go, 8'h00};
		if (f == 0 || f == 3)
			eo[7:4] = px[3:0];
		else if (f < 7)
			eo[7:0] = px[7:0];
		for (int i = 0; i < 12; i++) begin
			if (f == 7 && i < 9)
				{ee[i], eo[i]} = {1'b1, px[8 - i]};
			if (f == 8)
				{ee[i], eo[i]} = {1'b1, px[m12[i]]};
		end
		if (inv && f != 8)
			ee[11] = 1'b0;
		chk("pin enable", panel_data_pins_oe, ee);
		chk("pin data", panel_data_pins_out & ee, eo & ee);
		chk("timing", {frame_pulse, line_pulse, panel_shift_clock}, t[5:3]);
		chk("aux", panel_aux_out, f == 4 ? t[2] : f > 6 ? t[0] : t[1]);
		chk("power", panel_power_out, pw ? pol : !pol);
		chk("invert", video_invert, inv && f != 8 ? gi[3] : 1'b0);
	endtask : panel

	// --------------------
	// Sequence
	// --------------------
	initial begin
		void'($urandom(32'h9b17));
		for (int c = 0; c < 16; c++) begin
			do_reset(c);
			host_chk();
			for (int f = 0; f < 9; f++)
				panel(f, 1'($urandom));
			$display("test strap code %0d done", c);
		end
		close_out();
	end

	// Cuts a hang short
	initial begin
		#2000000;
		error_cnt++;
		close_out();
	end
endmodule : host_and_panel_pin_mux_test
`default_nettype wire
